// [include/ptc_defs.vh]
// register offsets, field positions and reset values for the trigger unit control block
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

`define PTC_ADDR_W          12
`define PTC_OFF_CTRL1       12'h538
`define PTC_OFF_TGT_NS      12'h530
`define PTC_OFF_TGT_S       12'h534
`define PTC_OFF_CMD         12'h540
`define PTC_OFF_STAT        12'h544
`define PTC_OFF_TIME_NS     12'h548
`define PTC_OFF_TIME_S      12'h54c

`define PTC_B_CHAIN_EN      31
`define PTC_B_CHAIN_LAST    30
`define PTC_F_UP_HI         27
`define PTC_F_UP_LO         26
`define PTC_B_FIRE_LATE     25
`define PTC_B_REPORT        24
`define PTC_B_FALL_EDGE     23
`define PTC_CTRL1_MASK      32'hcf800000
`define PTC_CTRL1_RST       32'h00000000

`define PTC_B_CMD_FIRE      0
`define PTC_B_CMD_SRST      1
`define PTC_B_CMD_IEN       2
`define PTC_B_CMD_CLR_DONE  3
`define PTC_B_CMD_CLR_ERR   4

`define PTC_NS_W            30
`define PTC_NS_MASK         32'h3fffffff
`define PTC_ZERO32          32'h00000000

`endif

// [design/ptc_time_cmp.v]
// target time comparator against the system time
`timescale 1ns/1ps
module ptc_time_cmp
(
    input  wire [31:0] tgt_s,
    input  wire [29:0] tgt_ns,
    input  wire [31:0] sys_s,
    input  wire [29:0] sys_ns,
    output wire        reached,
    output wire        late
);
    // -----------------------------------------------------------------
    // compare
    // -----------------------------------------------------------------
    assign late    = (tgt_s < sys_s) || ((tgt_s == sys_s) && (tgt_ns < sys_ns));
    assign reached = late || ((tgt_s == sys_s) && (tgt_ns == sys_ns));
endmodule // ptc_time_cmp

// [design/ptc_trigger_ctrl.v]
// trigger output unit: control word one, cascade start, fire and status
//
// Overview of operation
// (R1) bit 31 joins the unit to a cascade
// (R2) bit 30 marks unit as chain tail
// (R3) no tail anywhere: chain loops until soft reset
// (R4) bits 27:26 pick upstream done input
// (R5) bit 25 fires at once when late
// (R6) bit 24 gates done/error flags and interrupt
// (R7) bit 23 drives output on falling edge
// (R8) software enables fire only on chain head; the code arms any unit on a fire command
// (R9) soft reset returns unit to defaults
// (R10) bits 29:28 read zero; controls reset zero
`timescale 1ns/1ps
`include "ptc_defs.vh"
module ptc_trigger_ctrl
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire [11:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [31:0] sys_time_s,
    input  wire [29:0] sys_time_ns,
    input  wire [2:0]  upstream_done,
    input  wire        other_tail_set,
    output reg         unit_done_pulse,
    output wire        chain_enable,
    output wire        chain_tail,
    output reg         fire_done_flag,
    output reg         fire_error_flag,
    output wire        unit_irq,
    output wire        unit_active,
    output wire        trig_out,
    output wire        chain_endless
);
    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    reg  [31:0] ctrl1_ff;
    reg  [31:0] tgt_s_ff;
    reg  [29:0] tgt_ns_ff;
    reg         fire_en_ff;
    reg         irq_en_ff;
    reg         ack_ff;
    reg         pend_ff;
    reg         rise_out_ff;
    reg         fall_out_ff;
    reg  [2:0]  up_m_ff;
    reg  [2:0]  up_s_ff;
    reg         other_m_ff;
    reg         other_s_ff;
    wire        reached;
    wire        late;
    wire        req;
    wire        wr_hit;
    wire        soft_rst;
    wire        up_sel_done;
    wire        start;
    wire        fire;
    wire        err;
    wire [31:0] wmask;
    wire [31:0] nxt_tgt_ns;

    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [31:0] m;
        begin
            merge = (old_v & ~m) | (new_v & m);
        end
    endfunction

    ptc_time_cmp u_cmp
    (
        .tgt_s   (tgt_s_ff),
        .tgt_ns  (tgt_ns_ff),
        .sys_s   (sys_time_s),
        .sys_ns  (sys_time_ns),
        .reached (reached),
        .late    (late)
    );

    // -----------------------------------------------------------------
    // bus slave: one wait cycle, answer on the second edge
    // -----------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign wr_hit          = avs_write & ack_ff;
    assign wmask           = lane_mask(avs_byteenable);
    // top two bits of the word never reach the 30-bit target
    assign nxt_tgt_ns      = merge({2'b00, tgt_ns_ff}, avs_writedata, wmask & `PTC_NS_MASK);
    // (R9) soft reset strobe
    assign soft_rst        = wr_hit && (avs_address == `PTC_OFF_CMD) &&
                             avs_byteenable[0] && avs_writedata[`PTC_B_CMD_SRST];

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    // -----------------------------------------------------------------
    // upstream done inputs come from other logic domains: synchronise
    // -----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            up_m_ff    <= 3'h0;
            up_s_ff    <= 3'h0;
            other_m_ff <= 1'b0;
            other_s_ff <= 1'b0;
        end
        else
        begin
            up_m_ff    <= upstream_done;
            up_s_ff    <= up_m_ff;
            other_m_ff <= other_tail_set;
            other_s_ff <= other_m_ff;
        end
    end

    // (R1) cascade membership
    assign chain_enable  = ctrl1_ff[`PTC_B_CHAIN_EN];
    // (R2) tail marker
    assign chain_tail    = chain_enable & ctrl1_ff[`PTC_B_CHAIN_LAST];
    // (R3) endless loop when no unit is the tail
    assign chain_endless = chain_enable & ~ctrl1_ff[`PTC_B_CHAIN_LAST] & ~other_s_ff;
    // (R4) code 0 selects nothing, 1..3 an upstream unit
    assign up_sel_done   = (ctrl1_ff[`PTC_F_UP_HI:`PTC_F_UP_LO] == 2'h0) ? 1'b0 :
                           up_s_ff[ctrl1_ff[`PTC_F_UP_HI:`PTC_F_UP_LO] - 2'h1];
    // (R8) any unit armed by software, chain members also by upstream done
    assign start         = chain_enable & up_sel_done & ~pend_ff;
    // (R5) late target fires now only with fire-if-late
    assign fire          = pend_ff & (ctrl1_ff[`PTC_B_FIRE_LATE] ? reached : (reached & ~late));
    // a missed target without fire-if-late is an error
    assign err           = pend_ff & late & ~ctrl1_ff[`PTC_B_FIRE_LATE];
    assign unit_active   = pend_ff;
    // (R6) interrupt gated by report bit and enable
    assign unit_irq      = ctrl1_ff[`PTC_B_REPORT] & irq_en_ff & (fire_done_flag | fire_error_flag);

    // -----------------------------------------------------------------
    // control registers
    // -----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl1_ff   <= `PTC_CTRL1_RST;
            tgt_s_ff   <= `PTC_ZERO32;
            tgt_ns_ff  <= 30'h0;
            irq_en_ff  <= 1'b0;
        end
        // (R9) unit back to defaults
        else if (soft_rst)
        begin
            ctrl1_ff   <= `PTC_CTRL1_RST;
            tgt_s_ff   <= `PTC_ZERO32;
            tgt_ns_ff  <= 30'h0;
            irq_en_ff  <= 1'b0;
        end
        else if (wr_hit)
        begin
            // (R10) reserved bits never stored
            if (avs_address == `PTC_OFF_CTRL1)
                ctrl1_ff <= merge(ctrl1_ff, avs_writedata, wmask & `PTC_CTRL1_MASK);
            if (avs_address == `PTC_OFF_TGT_S)
                tgt_s_ff <= merge(tgt_s_ff, avs_writedata, wmask);
            if (avs_address == `PTC_OFF_TGT_NS)
                tgt_ns_ff <= nxt_tgt_ns[`PTC_NS_W-1:0];
            if ((avs_address == `PTC_OFF_CMD) && avs_byteenable[0])
                irq_en_ff <= avs_writedata[`PTC_B_CMD_IEN];
        end
    end

    // -----------------------------------------------------------------
    // arm, fire, flags; a flag set beats a same-cycle clear, a pend clear beats a same-cycle arm
    // -----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_ff         <= 1'b0;
            fire_en_ff      <= 1'b0;
            unit_done_pulse <= 1'b0;
            fire_done_flag  <= 1'b0;
            fire_error_flag <= 1'b0;
            rise_out_ff     <= 1'b0;
        end
        else if (soft_rst)
        begin
            pend_ff         <= 1'b0;
            fire_en_ff      <= 1'b0;
            unit_done_pulse <= 1'b0;
            fire_done_flag  <= 1'b0;
            fire_error_flag <= 1'b0;
            rise_out_ff     <= 1'b0;
        end
        else
        begin
            fire_en_ff      <= 1'b0;
            if (wr_hit && (avs_address == `PTC_OFF_CMD) && avs_byteenable[0])
            begin
                fire_en_ff <= avs_writedata[`PTC_B_CMD_FIRE];
                if (avs_writedata[`PTC_B_CMD_CLR_DONE])
                    fire_done_flag <= 1'b0;
                if (avs_writedata[`PTC_B_CMD_CLR_ERR])
                    fire_error_flag <= 1'b0;
            end
            if (fire_en_ff | start)
                pend_ff <= 1'b1;
            if (fire | err)
                pend_ff <= 1'b0;
            unit_done_pulse <= fire;
            if (fire)
                rise_out_ff <= ~rise_out_ff;
            // (R6) flags reported only with report bit
            if (fire && ctrl1_ff[`PTC_B_REPORT])
                fire_done_flag <= 1'b1;
            if (err && ctrl1_ff[`PTC_B_REPORT])
                fire_error_flag <= 1'b1;
        end
    end

    // (R7) falling-edge copy of the output
    always @(negedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fall_out_ff <= 1'b0;
        else
            fall_out_ff <= rise_out_ff;
    end
    // (R7) edge select
    assign trig_out = ctrl1_ff[`PTC_B_FALL_EDGE] ? fall_out_ff : rise_out_ff;

    // -----------------------------------------------------------------
    // read data, held in a flop; unmapped reads give zero
    // -----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= `PTC_ZERO32;
        else if (avs_read & ~ack_ff)
        begin
            case (avs_address)
                `PTC_OFF_CTRL1:   avs_readdata <= ctrl1_ff;
                `PTC_OFF_TGT_S:   avs_readdata <= tgt_s_ff;
                `PTC_OFF_TGT_NS:  avs_readdata <= {2'b00, tgt_ns_ff};
                `PTC_OFF_CMD:     avs_readdata <= {29'h0, irq_en_ff, 2'b00};
                `PTC_OFF_STAT:    avs_readdata <= {26'h0, chain_endless, trig_out, unit_irq,
                                                   fire_error_flag, fire_done_flag, pend_ff};
                `PTC_OFF_TIME_S:  avs_readdata <= sys_time_s;
                `PTC_OFF_TIME_NS: avs_readdata <= {2'b00, sys_time_ns};
                default:          avs_readdata <= `PTC_ZERO32;
            endcase
        end
    end
endmodule // ptc_trigger_ctrl

// [test/ptc_trigger_ctrl_chk.sv]
// port assertions for the trigger unit control block
`timescale 1ns/1ps
module ptc_trigger_ctrl_chk
(
    input wire        clk,
    input wire        rst_b,
    input wire [11:0] avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        unit_done_pulse,
    input wire        chain_enable,
    input wire        chain_tail,
    input wire        fire_done_flag,
    input wire        fire_error_flag,
    input wire        unit_irq,
    input wire        unit_active,
    input wire        trig_out,
    input wire        chain_endless
);
    // ----------------------------
    // bus and control word checks
    // ----------------------------
    wire wr_ack = avs_write & ~avs_waitrequest;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_chain_en_load: assert property (wr_ack && avs_address == 12'h538 && avs_byteenable[3]
        |=> chain_enable == $past(avs_writedata[31])) else $error("chain enable not loaded");
    a_chain_tail_load: assert property (wr_ack && avs_address == 12'h538 && avs_byteenable[3]
        |=> chain_tail == ($past(avs_writedata[31]) && $past(avs_writedata[30])))
        else $error("chain tail not loaded");
    a_endless_no_tail: assert property (chain_endless |-> chain_enable && !chain_tail)
        else $error("endless without open chain");
    a_irq_needs_flag: assert property (unit_irq |-> fire_done_flag || fire_error_flag)
        else $error("irq without flag");
    a_reserved_zero: assert property (avs_read && !avs_waitrequest && avs_address == 12'h538
        |-> avs_readdata[29:28] == 2'h0 && avs_readdata[22:0] == 23'h0) else $error("reserved bits set");
    // one wait cycle per request
    a_one_wait_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state count wrong");
    a_fire_pulse_one: assert property (unit_done_pulse |=> !unit_done_pulse && !unit_active)
        else $error("fire pulse too long");
    a_soft_reset_clr: assert property (wr_ack && avs_address == 12'h540 && avs_byteenable[0]
        && avs_writedata[1] |=> !chain_enable && !unit_active && !fire_done_flag && !fire_error_flag
        && !trig_out) else $error("soft reset left state");
endmodule // ptc_trigger_ctrl_chk

bind ptc_trigger_ctrl ptc_trigger_ctrl_chk i_chk
(
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .unit_done_pulse(unit_done_pulse), .chain_enable(chain_enable),
    .chain_tail(chain_tail), .fire_done_flag(fire_done_flag), .fire_error_flag(fire_error_flag),
    .unit_irq(unit_irq), .unit_active(unit_active), .trig_out(trig_out), .chain_endless(chain_endless)
);

// [test/tb_ptp_trigger_output_control.sv]
// self-checking bench for the trigger unit control block
`timescale 1ns/1ps
`include "ptc_defs.vh"
module tb_ptp_trigger_output_control;
    reg         clk;
    reg         rst_b;
    reg  [11:0] avs_address;
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    reg  [3:0]  avs_byteenable;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    reg  [31:0] sys_time_s;
    reg  [29:0] sys_time_ns;
    reg  [2:0]  upstream_done;
    reg         other_tail_set;
    wire        unit_done_pulse;
    wire        chain_enable;
    wire        chain_tail;
    wire        fire_done_flag;
    wire        fire_error_flag;
    wire        unit_irq;
    wire        unit_active;
    wire        trig_out;
    wire        chain_endless;
    reg         last_edge;
    reg  [31:0] q;
    reg         t;
    int         fails;
    int         samples_checked;
    int         i;

    ptc_trigger_ctrl i_dut
    (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sys_time_s(sys_time_s), .sys_time_ns(sys_time_ns),
        .upstream_done(upstream_done), .other_tail_set(other_tail_set), .unit_done_pulse(unit_done_pulse),
        .chain_enable(chain_enable), .chain_tail(chain_tail), .fire_done_flag(fire_done_flag),
        .fire_error_flag(fire_error_flag), .unit_irq(unit_irq), .unit_active(unit_active),
        .trig_out(trig_out), .chain_endless(chain_endless)
    );

    always #25 clk = ~clk;
    // clock level at each output change tells which edge drove it
    always @(trig_out) if (rst_b === 1'b1) last_edge = clk;

    // ----------------------------
    // bus tasks and compare
    // ----------------------------
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_byteenable <= be;
            avs_read <= !w;
            avs_write <= w;
            // hold until the rising edge that samples waitrequest low
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) @(posedge clk);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        begin
            samples_checked++;
            if (s !== e)
            begin
                fails++;
                $display("CHECK FAILED %s exp %h seen %h", n, e, s);
            end
        end
    endtask
    task automatic fire(input logic [31:0] ctl, input logic [31:0] tgt);
        begin
            wr(`PTC_OFF_CTRL1, ctl);
            wr(`PTC_OFF_TGT_NS, tgt);
            wr(`PTC_OFF_CMD, 32'h0000001c);
            wr(`PTC_OFF_CMD, 32'h00000005);
        end
    endtask
    task automatic wait_fire;
        begin
            i = 0;
            while (unit_done_pulse !== 1'b1 && i < 50)
            begin
                @(negedge clk);
                i++;
            end
            chk("fire", unit_done_pulse, 1'b1);
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic stop_test;
        begin
            $display("checks %0d fails %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    initial
    begin
        #400000;
        fails++;
        stop_test;
    end

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        avs_address <= 12'h000;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h00000000;
        avs_byteenable <= 4'h0;
        sys_time_s <= 32'h00000000;
        sys_time_ns <= 30'd100;
        upstream_done <= 3'h0;
        other_tail_set <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, `PTC_OFF_CTRL1, 0, 4'hf);
        chk("ctrl1 rst", q, 32'h00000000);
        chk("outs rst", {chain_enable, chain_tail, fire_done_flag, fire_error_flag, trig_out}, 0);
        wr(`PTC_OFF_CTRL1, 32'hffffffff);
        bus(1'b0, `PTC_OFF_CTRL1, 0, 4'hf);
        chk("ctrl1 mask", q, 32'hcf800000);
        chk("chain en", {chain_enable, chain_tail}, 2'h3);
        bus(1'b1, `PTC_OFF_CTRL1, 0, 4'h7);
        bus(1'b0, `PTC_OFF_CTRL1, 0, 4'hf);
        chk("ctrl1 be", q, 32'hcf000000);
        bus(1'b0, 12'h100, 0, 4'hf);
        chk("unmapped", q, 32'h00000000);
        wr(`PTC_OFF_CTRL1, 32'h80000000);
        repeat (4) @(posedge clk);
        chk("endless", chain_endless, 1'b1);
        other_tail_set <= 1'b1;
        repeat (4) @(posedge clk);
        chk("tail elsewhere", chain_endless, 1'b0);
        other_tail_set <= 1'b0;
        fire(32'h01000000, 200);
        repeat (5) @(posedge clk);
        chk("armed", {unit_active, fire_done_flag}, 2'h2);
        sys_time_ns <= 30'd200;
        wait_fire;
        chk("done", {fire_done_flag, unit_irq, trig_out, last_edge}, 4'hf);
        bus(1'b0, `PTC_OFF_STAT, 0, 4'hf);
        chk("stat", q, 32'h0000001a);
        bus(1'b0, `PTC_OFF_CMD, 0, 4'hf);
        chk("cmd", q, 32'h00000004);
        fire(32'h01000000, 10);
        repeat (6) @(posedge clk);
        chk("late err", {fire_error_flag, fire_done_flag, unit_active, trig_out}, 4'h9);
        fire(32'h03800000, 10);
        wait_fire;
        chk("late fire", {fire_done_flag, fire_error_flag, trig_out, last_edge}, 4'h8);
        fire(32'h02000000, 10);
        wait_fire;
        chk("no report", {fire_done_flag, unit_irq, trig_out}, 3'h1);
        wr(`PTC_OFF_TGT_S, 32'h00000001);
        bus(1'b0, `PTC_OFF_TGT_S, 0, 4'hf);
        chk("tgt s", q, 32'h00000001);
        fire(32'h03000000, 10);
        repeat (5) @(posedge clk);
        chk("sec armed", unit_active, 1'b1);
        sys_time_s <= 32'h00000001;
        wait_fire;
        chk("sec fire", {fire_done_flag, trig_out}, 2'h2);
        // upstream select, follower fired by the selected upstream done, not by another source
        for (int c = 1; c < 4; c++)
        begin
            wr(`PTC_OFF_CTRL1, 32'h82000000 | (c << 26));
            t = trig_out;
            upstream_done <= 3'h1 << (c % 3);
            @(posedge clk);
            upstream_done <= 3'h0;
            repeat (6) @(posedge clk);
            chk("wrong src", trig_out, t);
            upstream_done <= 3'h1 << (c - 1);
            @(posedge clk);
            upstream_done <= 3'h0;
            wait_fire;
            chk("right src", trig_out, !t);
        end
        wr(`PTC_OFF_CTRL1, 32'hffffffff);
        wr(`PTC_OFF_CMD, 32'h00000002);
        bus(1'b0, `PTC_OFF_CTRL1, 0, 4'hf);
        chk("srst ctrl1", q, 32'h00000000);
        bus(1'b0, `PTC_OFF_TGT_NS, 0, 4'hf);
        chk("srst tgt", q, 32'h00000000);
        bus(1'b0, `PTC_OFF_TGT_S, 0, 4'hf);
        chk("srst tgt s", q, 32'h00000000);
        chk("srst outs", {chain_enable, fire_done_flag, fire_error_flag, unit_active, trig_out}, 0);
        stop_test;
    end
endmodule // tb_ptp_trigger_output_control
